// *** core/sbam_arbiter.sv ***
// serial bus arbitration monitor, arbitration mode logic
// Notes on behaviour
// - mode field value 10 selects bus arbitration mode.
// - in arbitration mode each rising internal transmit edge starts the counter.
// - receive line is sampled once at count 38h (clock select 0) or 08h (1).
// - a low receive level at that sample sets the arbitration-lost flag.
// - while the lost flag is set the transmit pin is held at 1.
// - transmit falling to 0 before a low sample resets the counter.
// - the counter is nine bits plus one overflow bit.
// - counter steps at half bus clock, or half prescaler clock if selected.
// - the lost flag is read-only, cleared by upper mode bit 0 and by reset.
// - mode 00 holds the arbiter idle with counter reset; 11 is reserved.
`timescale 1ns/1ps
`include "sbam_defines.svh"
module sbam_arbiter
	import sbam_pkg::*;
#(
	parameter int CNT_WIDTH = `SBAM_CNT_WIDTH
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// control from the serial module
	input wire sbam_ctrl_type ctrl,
	input wire logic prescaler_tick,
	input wire logic internal_serial_transmit,
	// bus pins
	input wire logic rx_pin,
	output logic tx_pin,
	// status
	output logic arbitration_lost_flag,
	output logic counter_running,
	output logic [CNT_WIDTH:0] counter_value
);

	logic rx_sync;
	logic tx_d_ff;
	logic nxt_tx_d;
	logic half_ff;
	logic nxt_half;
	logic [CNT_WIDTH:0] cnt_ff;
	logic [CNT_WIDTH:0] nxt_cnt;
	sbam_state_type state_ff;
	sbam_state_type nxt_state;
	logic lost_ff;
	logic nxt_lost;
	logic tx_pin_ff;
	logic nxt_tx_pin;
	logic run_ff;
	logic nxt_run;
	logic arb_mode;
	logic tx_rise;
	logic tx_low;
	logic src_tick;
	logic [CNT_WIDTH:0] sample_at;
	logic lost_set;
	logic at_sample;
	logic rx_dominant;
	logic cnt_step;

	// receive pin comes from the bus, so it is synchronised first
	sbam_sync u_rx_sync
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.pin_in(rx_pin),
		.pin_sync(rx_sync)
	);

	assign arb_mode = (ctrl.arbiter_mode_select == `SBAM_MODE_ARB);
	assign tx_rise = internal_serial_transmit & ~tx_d_ff;
	assign tx_low = ~internal_serial_transmit;
	// bus clock source ticks every cycle; prescaler only on its tick
	assign src_tick = ctrl.clk_select ? prescaler_tick : 1'h1;
	assign sample_at = ctrl.clk_select ? `SBAM_SAMPLE_PRE
		: `SBAM_SAMPLE_BUS;

	// counter sits exactly on its sample point this cycle
	assign at_sample = (cnt_ff == sample_at);
	// the bus reads dominant when the synced receive level is low
	assign rx_dominant = ~rx_sync;
	// one counter step needs two source ticks
	assign cnt_step = src_tick & half_ff;

	// next state of the arbiter counter and sequencer
	always_comb
	begin
		nxt_half = half_ff;
		nxt_cnt = cnt_ff;
		nxt_state = state_ff;
		lost_set = 1'h0;
		nxt_run = 1'h0;
		if (!arb_mode)
		begin
			// idle, measurement or reserved code: counter held reset
			nxt_state = SBAM_IDLE;
			nxt_cnt = '0;
			nxt_half = 1'h0;
		end
		else
		begin
			unique case (state_ff)
				SBAM_IDLE:
				begin
					if (tx_rise)
					begin
						nxt_state = SBAM_COUNT;
						nxt_cnt = '0;
						nxt_half = 1'h0;
					end
				end
				SBAM_COUNT:
				begin
					nxt_run = 1'h1;
					if (tx_low)
					begin
						// dropped before a dominant sample: restart
						nxt_state = SBAM_IDLE;
						nxt_cnt = '0;
					end
					else if (at_sample)
					begin
						// single static sample of the bus
						if (rx_dominant)
							lost_set = 1'h1;
						nxt_state = SBAM_DONE;
					end
					else if (src_tick)
					begin
						// divide by two; top bit is the overflow bit
						nxt_half = ~half_ff;
						if (cnt_step)
							nxt_cnt = cnt_ff + 1'h1;
					end
				end
				SBAM_DONE:
				begin
					// wait for the bit to end before rearming
					if (tx_low)
					begin
						nxt_state = SBAM_IDLE;
						nxt_cnt = '0;
					end
				end
				default:
					nxt_state = SBAM_IDLE;
			endcase
		end
	end

	// register the arbiter counter and sequencer
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			half_ff <= 1'h0;
			cnt_ff <= '0;
			state_ff <= SBAM_IDLE;
			run_ff <= 1'h0;
		end
		else
		begin
			half_ff <= nxt_half;
			cnt_ff <= nxt_cnt;
			state_ff <= nxt_state;
			run_ff <= nxt_run;
		end
	end

	// lost flag: clear by upper mode bit 0; a same-cycle set wins
	always_comb
	begin
		nxt_lost = lost_ff;
		if (ctrl.mode_upper_clear || !ctrl.arbiter_mode_select[1])
			nxt_lost = 1'h0;
		if (lost_set)
			nxt_lost = 1'h1;
	end

	// register the lost flag; software cannot write it directly
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			lost_ff <= 1'h0;
		else
			lost_ff <= nxt_lost;
	end

	// edge detector and pin driver; the pin uses the next flag value so
	// the forced level appears in the same cycle as the flag
	always_comb
	begin
		nxt_tx_d = internal_serial_transmit;
		nxt_tx_pin = nxt_lost ? 1'h1 : internal_serial_transmit;
	end

	// register the transmit path; the pin idles recessive in reset
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_d_ff <= 1'h0;
			tx_pin_ff <= 1'h1;
		end
		else
		begin
			tx_d_ff <= nxt_tx_d;
			tx_pin_ff <= nxt_tx_pin;
		end
	end

	assign tx_pin = tx_pin_ff;
	assign arbitration_lost_flag = lost_ff;
	assign counter_running = run_ff;
	assign counter_value = cnt_ff;

endmodule

// *** core/sbam_defines.svh ***
// constants for the serial bus arbitration monitor
`ifndef SBAM_DEFINES_SVH
`define SBAM_DEFINES_SVH

`define SBAM_MODE_IDLE 2'h0
`define SBAM_MODE_MEASURE 2'h1
`define SBAM_MODE_ARB 2'h2
`define SBAM_MODE_RSVD 2'h3
`define SBAM_CNT_WIDTH 9
`define SBAM_SAMPLE_BUS 10'h038
`define SBAM_SAMPLE_PRE 10'h008

`endif

// *** core/sbam_pkg.sv ***
// types for the serial bus arbitration monitor
package sbam_pkg;

	// control inputs that steer the arbiter
	typedef struct packed {
		logic [1:0] arbiter_mode_select;
		logic clk_select;
		logic mode_upper_clear;
	} sbam_ctrl_type;

	// arbiter state
	typedef enum logic [1:0] {
		SBAM_IDLE,
		SBAM_COUNT,
		SBAM_DONE
	} sbam_state_type;

endpackage

// *** core/sbam_sync.sv ***
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module sbam_sync
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// pin side and synced side
	input wire logic pin_in,
	output logic pin_sync
);

	logic meta_ff;
	logic sync_ff;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_ff <= 1'h1;
			sync_ff <= 1'h1;
		end
		else
		begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign pin_sync = sync_ff;

endmodule

// *** verif/sbam_arbiter_sva.sv ***
// arbitration monitor checker
`timescale 1ns/1ps
module sbam_arbiter_sva
	import sbam_pkg::*;
#(parameter int CNT_WIDTH = 9)
(
	// watched ports
	input wire logic mclk,
	input wire logic reset_n,
	input wire sbam_ctrl_type ctrl,
	input wire logic internal_serial_transmit,
	input wire logic tx_pin,
	input wire logic arbitration_lost_flag,
	input wire logic counter_running,
	input wire logic [CNT_WIDTH:0] counter_value
);
	// short names; p is the sample count of the chosen clock
	wire f = arbitration_lost_flag;
	wire r = counter_running;
	wire [CNT_WIDTH:0] v = counter_value;
	wire [CNT_WIDTH:0] p = ctrl.clk_select ? 10'h008 : 10'h038;
	wire m = ctrl.arbiter_mode_select == 2'h2;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	tx_forced_a:
	assert property (f |-> tx_pin) else $error("tx");
	start_count_a:
	assert property ($rose(internal_serial_transmit) && m && !r && !v && !f
		|-> ##2 r) else $error("start");
	sample_point_a:
	assert property ($rose(f) |-> v == p) else $error("point");
	count_cap_a:
	assert property (v <= 10'h038) else $error("cap");
	half_rate_a:
	assert property ($changed(v) && !ctrl.clk_select |=> $stable(v))
		else $error("rate");
	abort_reset_a:
	assert property ($fell(internal_serial_transmit) && r && !f |=> !v)
		else $error("abort");
	mode_idle_a:
	assert property (!m |=> !v && !r) else $error("idle");
	clear_flag_a:
	assert property (!ctrl.arbiter_mode_select[1] |=> !f) else $error("clr");
endmodule
bind sbam_arbiter sbam_arbiter_sva #(.CNT_WIDTH(CNT_WIDTH)) sva_i (.*);

// *** verif/sbam_bus_node.sv ***
// other node on the wired-AND bus
`timescale 1ns/1ps
module sbam_bus_node
(
	// our pin, the other node's drive, bus level
	input wire logic tx_pin,
	input wire logic dominant,
	output logic rx_pin
);
	// a low from any node wins the line
	assign rx_pin = tx_pin & ~dominant;
endmodule

// *** verif/sbam_arbiter_bench.sv ***
// arbitration monitor bench
`timescale 1ns/1ps
module sbam_arbiter_bench
	import sbam_pkg::*;
;
	logic mclk = 0, reset_n = 0, ist = 0, dom = 0, tx, rx, f, run;
	logic [1:0] pc = 2'h0;
	logic [9:0] v;
	sbam_ctrl_type c = '0;
	int fail_count = 0, n_tests = 0;
	// clock, and a prescaler tick every fourth cycle
	always #4 mclk = ~mclk;
	always @(negedge mclk) pc <= pc + 2'h1;
	sbam_arbiter sbam_arbiter_i (.mclk, .reset_n, .ctrl(c),
		.prescaler_tick(pc == 2'h0), .internal_serial_transmit(ist),
		.rx_pin(rx), .tx_pin(tx), .arbitration_lost_flag(f),
		.counter_running(run), .counter_value(v));
	sbam_bus_node sbam_bus_node_i (.tx_pin(tx), .dominant(dom), .rx_pin(rx));
	task automatic chk(string n, logic [9:0] e, logic [9:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("fails %0d checks %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one bit with TX high; d makes the other node dominant
	task automatic arb(logic s, logic d);
		c.clk_select = s;
		dom = d;
		ist = 1;
		repeat (300) @(negedge mclk);
	endtask
	task automatic t_lose();
		arb(0, 1);
		chk("f", 10'h1, f);
		chk("v", 10'h038, v);
		ist = 0;
		@(negedge mclk);
		chk("tx", 10'h1, tx);
		c.arbiter_mode_select = 2'h0;
		repeat (2) @(negedge mclk);
		chk("f", 10'h0, f);
		chk("v", 10'h0, v);
		c.arbiter_mode_select = 2'h2;
	endtask
	task automatic t_win();
		arb(1, 0);
		chk("f", 10'h0, f);
		chk("v", 10'h008, v);
		ist = 0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic t_abort();
		c.clk_select = 0;
		ist = 1;
		repeat (20) @(negedge mclk);
		chk("run", 10'h1, run);
		chk("v", 10'h009, v);
		ist = 0;
		repeat (2) @(negedge mclk);
		chk("v", 10'h0, v);
	endtask
	// lose again, then clear by the upper-bit write pulse
	task automatic t_clear_pulse();
		arb(0, 1);
		chk("f", 10'h1, f);
		c.mode_upper_clear = 1;
		@(negedge mclk);
		c.mode_upper_clear = 0;
		chk("f", 10'h0, f);
		ist = 0;
		@(negedge mclk);
	endtask
	// leaving arbitration mode resets; measurement mode 01 never arbitrates
	task automatic t_idle();
		dom = 0;
		ist = 1;
		repeat (20) @(negedge mclk);
		c.arbiter_mode_select = 2'h1;
		repeat (2) @(negedge mclk);
		chk("v", 10'h0, v);
		chk("run", 10'h0, run);
		ist = 0;
		@(negedge mclk);
		ist = 1;
		repeat (20) @(negedge mclk);
		chk("v", 10'h0, v);
		chk("run", 10'h0, run);
		ist = 0;
		c.arbiter_mode_select = 2'h2;
		@(negedge mclk);
	endtask
	// watchdog far past the eight microsecond run
	initial #50000
	begin
		fail_count++;
		stop_test();
	end
	// reset for 16 cycles, then the scenarios
	initial
	begin
		repeat (16) @(negedge mclk);
		reset_n = 1;
		c.arbiter_mode_select = 2'h2;
		t_lose();
		t_win();
		t_abort();
		t_clear_pulse();
		t_idle();
		stop_test();
	end
endmodule
